// *** pkg/phs_pkg.sv ***
// Shared constants and types for the pattern handshake port
package phs_pkg;
	localparam int unsigned DATA_W            = 32;
	localparam int unsigned FIFO_DEPTH        = 16;
	localparam int unsigned CNT_W             = 4;

	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned IN_REQ_MIN_NS     = 50;
	localparam int unsigned IN_ACK_PULSE_NS   = 100;
	localparam int unsigned MIN_HS_CYCLE_NS   = 100;
	localparam int unsigned OUT_REQ_PULSE_NS  = 100;
	localparam int unsigned OUT_ACK_RECOG_NS  = 100;
	localparam int unsigned OUT_SETTLE_CYC_I  = 1;

	// Least times round up, never below one cycle
	localparam int unsigned IN_REQ_MIN_CYC_I  = (IN_REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IN_ACK_CYC_I      = (IN_ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MIN_HS_CYC_I      = (MIN_HS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OUT_REQ_CYC_I     = (OUT_REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OUT_ACK_CYC_I     = (OUT_ACK_RECOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [CNT_W-1:0] IN_REQ_MIN_CYC = CNT_W'(IN_REQ_MIN_CYC_I < 1 ? 1 : IN_REQ_MIN_CYC_I);
	localparam logic [CNT_W-1:0] IN_ACK_CYC     = CNT_W'(IN_ACK_CYC_I < 1 ? 1 : IN_ACK_CYC_I);
	localparam logic [CNT_W-1:0] MIN_HS_CYC     = CNT_W'(MIN_HS_CYC_I < 1 ? 1 : MIN_HS_CYC_I);
	localparam logic [CNT_W-1:0] OUT_REQ_CYC    = CNT_W'(OUT_REQ_CYC_I < 1 ? 1 : OUT_REQ_CYC_I);
	localparam logic [CNT_W-1:0] OUT_ACK_CYC    = CNT_W'(OUT_ACK_CYC_I < 1 ? 1 : OUT_ACK_CYC_I);
	localparam logic [CNT_W-1:0] OUT_SETTLE_CYC = CNT_W'(OUT_SETTLE_CYC_I);

	localparam logic [CNT_W-1:0]  CNT_ZERO      = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RESET    = 32'h0000_0000;

	typedef enum logic [1:0] {
		PHS_IN_IDLE  = 2'b00,
		PHS_IN_WRITE = 2'b01,
		PHS_IN_ACK   = 2'b10
	} phs_in_state_e;

	typedef enum logic [2:0] {
		PHS_OUT_IDLE   = 3'b000,
		PHS_OUT_FETCH  = 3'b001,
		PHS_OUT_SETTLE = 3'b010,
		PHS_OUT_REQ    = 3'b011,
		PHS_OUT_WAIT   = 3'b100
	} phs_out_state_e;
endpackage

// *** testbench/phs_ext_dev.sv ***
// Behavioural external pattern source and sink
`timescale 1ns/100ps
`default_nettype none
module phs_ext_dev (
	input wire logic                        ref_clk,
	input wire logic [1:0]                  ack_gap,
	input wire logic                        in_acknowledge_n,
	input wire logic                        out_request_n,
	output var logic                        in_request_n,
	output var logic [phs_pkg::DATA_W-1:0]  in_data,
	output var logic                        out_acknowledge_n
);
	import phs_pkg::*;
	logic [DATA_W-1:0] tx_q[$];
	logic [DATA_W-1:0] w;
	initial begin
		in_request_n = 1'b1;
		in_data = 32'h5a5a_a5a5;
		forever begin
			@(negedge ref_clk);
			if (tx_q.size() != 0) begin
				w = tx_q.pop_front();
				in_request_n <= 1'b0;
				in_data <= w;
				@(negedge ref_clk);
				in_request_n <= 1'b1;
				in_data <= ~w;
				// Next strobe only once answered
				@(negedge in_acknowledge_n);
				@(posedge in_acknowledge_n);
			end else begin
				in_data <= ~in_data;
			end
		end
	end
	initial begin
		out_acknowledge_n = 1'b1;
		forever begin
			@(posedge ref_clk);
			if (out_request_n === 1'b0) begin
				repeat (ack_gap) @(posedge ref_clk);
				@(negedge ref_clk);
				out_acknowledge_n <= 1'b0;
				@(negedge ref_clk);
				out_acknowledge_n <= 1'b1;
			end
		end
	end
endmodule // phs_ext_dev
`default_nettype wire

// *** testbench/phs_top_monitor.sv ***
// Concurrent checks on the pattern handshake port
`timescale 1ns/100ps
`default_nettype none
module phs_top_monitor (
	input wire logic                       ref_clk,
	input wire logic                       reset,
	input wire logic                       in_mode_en,
	input wire logic                       in_request_n,
	input wire logic                       in_acknowledge_n,
	input wire logic                       bm_wr_req,
	input wire logic [phs_pkg::DATA_W-1:0] bm_wr_data,
	input wire logic                       bm_wr_done,
	input wire logic                       src_valid,
	input wire logic                       src_ready,
	input wire logic                       out_request_n,
	input wire logic                       out_acknowledge_n,
	input wire logic [phs_pkg::DATA_W-1:0] out_data
);
	import phs_pkg::*;
	default clocking mc @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic       req_q_r;
	logic [5:0] pend_r;
	logic       wait_r;
	wire logic  strobe;
	assign strobe = in_mode_en && !in_request_n && req_q_r;
	always_ff @(posedge ref_clk) begin
		req_q_r <= reset | in_request_n;
		pend_r <= reset ? 6'h00 : pend_r + 6'(strobe) - 6'(bm_wr_req && bm_wr_done);
		wait_r <= !reset && (!out_request_n || (wait_r && !src_ready));
	end
	sequence s_take;
		src_valid && src_ready;
	endsequence
	sequence s_offer;
		($fell(out_request_n) && $stable(out_data)) ##1 out_request_n;
	endsequence
	wr_start_a: assert property (strobe |-> ##[2:60] bm_wr_req) else $error("no host write after strobe");
	wr_cause_a: assert property ($rose(bm_wr_req) |-> pend_r != 6'h00) else $error("write without strobe");
	wr_hold_a: assert property (bm_wr_req && !bm_wr_done |=> bm_wr_req && $stable(bm_wr_data))
		else $error("write dropped or data moved");
	ack_done_a: assert property (bm_wr_req && bm_wr_done |=> !in_acknowledge_n && !bm_wr_req)
		else $error("no acknowledge after write");
	ack_width_a: assert property ($fell(in_acknowledge_n) |=> in_acknowledge_n) else $error("ack width wrong");
	ack_cause_a: assert property ($fell(in_acknowledge_n) |-> $past(bm_wr_done)) else $error("ack without write");
	offer_timing_a: assert property (s_take |-> ##2 s_offer) else $error("offer timing wrong");
	ack_next_a: assert property ((wait_r || !out_request_n) && !out_acknowledge_n && !src_ready |=> src_ready)
		else $error("next word not fetched");
endmodule // phs_top_monitor
bind phs_top phs_top_monitor mon (.ref_clk(ref_clk), .reset(reset), .in_mode_en(in_mode_en),
	.in_request_n(in_request_n), .in_acknowledge_n(in_acknowledge_n), .bm_wr_req(bm_wr_req),
	.bm_wr_data(bm_wr_data), .bm_wr_done(bm_wr_done), .src_valid(src_valid), .src_ready(src_ready),
	.out_request_n(out_request_n), .out_acknowledge_n(out_acknowledge_n), .out_data(out_data));
`default_nettype wire

// *** testbench/phs_top_tb_top.sv ***
// Self-checking bench for the pattern handshake port
`timescale 1ns/100ps
`default_nettype none
module phs_top_tb_top;
	import phs_pkg::*;
	localparam int N = 24;
	logic              ref_clk = 1'b0;
	logic              reset = 1'b1;
	logic              in_mode_en = 1'b0;
	logic              out_mode_en = 1'b0;
	logic              bm_wr_done = 1'b0;
	logic              src_valid = 1'b0;
	logic [DATA_W-1:0] src_data = 32'h0000_0000;
	logic [1:0]        ack_gap = 2'h0;
	wire logic         in_request_n, in_acknowledge_n, bm_wr_req, src_ready, out_request_n, out_acknowledge_n;
	wire logic         in_overrun;
	wire logic [DATA_W-1:0] in_data, bm_wr_data, out_data;
	integer            seed = 32'hbeeb_c4f5;
	integer            errors = 0;
	integer            cmp_count = 0;
	integer            wr_n = 0;
	integer            out_n = 0;
	bit                took = 1'b0;
	logic [DATA_W-1:0] w;
	logic [DATA_W-1:0] exp_in[$];
	logic [DATA_W-1:0] exp_out[$];
	phs_top uut (.ref_clk(ref_clk), .reset(reset), .in_mode_en(in_mode_en), .out_mode_en(out_mode_en),
		.in_request_n(in_request_n), .in_data(in_data), .in_acknowledge_n(in_acknowledge_n),
		.bm_wr_req(bm_wr_req), .bm_wr_data(bm_wr_data), .bm_wr_done(bm_wr_done), .src_valid(src_valid),
		.src_data(src_data), .src_ready(src_ready), .out_request_n(out_request_n),
		.out_acknowledge_n(out_acknowledge_n), .out_data(out_data), .in_overrun(in_overrun));
	phs_ext_dev dev (.ref_clk(ref_clk), .ack_gap(ack_gap), .in_acknowledge_n(in_acknowledge_n),
		.out_request_n(out_request_n), .in_request_n(in_request_n), .in_data(in_data),
		.out_acknowledge_n(out_acknowledge_n));
	always #50 ref_clk = ~ref_clk;
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Scoreboard at the sampling edge; an empty queue expects nothing
	always @(posedge ref_clk) begin
		if (!reset && bm_wr_req && bm_wr_done) begin
			check(bm_wr_data, exp_in.size() != 0 ? exp_in.pop_front() : 32'hxxxx_xxxx);
			wr_n++;
		end
		if (!reset && out_request_n === 1'b0) begin
			check(out_data, exp_out.size() != 0 ? exp_out.pop_front() : 32'hxxxx_xxxx);
			out_n++;
		end
		if (src_valid && src_ready === 1'b1) begin
			exp_out.push_back(src_data);
			took = 1'b1;
		end
	end
	// Host memory stalls at random; word source holds until taken
	always @(negedge ref_clk) begin
		bm_wr_done <= bm_wr_req && !bm_wr_done && (($random(seed) & 3) == 0);
		ack_gap <= 2'($random(seed));
		if (took || !src_valid) begin
			src_valid <= 1'($random(seed));
			src_data <= DATA_W'($random(seed));
		end
		took = 1'b0;
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		reset <= 1'b0;
		// Modes off: noisy data lines must never be written
		repeat (6) @(negedge ref_clk);
		in_mode_en <= 1'b1;
		out_mode_en <= 1'b1;
		for (int i = 0; i < N; i++) begin
			w = DATA_W'($random(seed));
			exp_in.push_back(w);
			dev.tx_q.push_back(w);
		end
		for (int k = 0; k < 4000 && (wr_n < N || out_n < N); k++) @(negedge ref_clk);
		out_mode_en <= 1'b0;
		repeat (20) @(negedge ref_clk);
		check(32'(wr_n), 32'(N));
		check(32'(exp_in.size()), 32'h0000_0000);
		check(32'(exp_out.size()), 32'h0000_0000);
		check({31'h0000_0000, in_overrun}, 32'h0000_0000);
		close_out();
	end
	initial begin
		#(100 * 6000);
		errors++;
		close_out();
	end
endmodule // phs_top_tb_top
`default_nettype wire

// *** verilog/phs_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module phs_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge ref_clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // phs_fifo
`default_nettype wire

// *** verilog/phs_low_filter.sv ***
// Recognises a low pulse of a minimum length on an active-low line
`timescale 1ns/100ps
`default_nettype none
module phs_low_filter #(
	parameter int unsigned CNT_W = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             enable,
	input  wire logic [CNT_W-1:0] min_cyc,
	input  wire logic             line_n,
	output logic                  recognised
);
	logic [CNT_W-1:0] low_cnt_r;
	logic             fired_r;
	logic             reached;
	logic [CNT_W-1:0] low_cnt_nxt;

	assign low_cnt_nxt = (low_cnt_r == {CNT_W{1'b1}}) ? low_cnt_r : low_cnt_r + 1'b1;
	assign reached     = enable && !line_n && !fired_r && (low_cnt_nxt >= min_cyc);
	assign recognised  = reached;

	// One event per pulse; line must return high before the next
	always_ff @(posedge ref_clk) begin
		if (reset || !enable || line_n) begin
			low_cnt_r <= '0;
			fired_r   <= 1'b0;
		end else begin
			low_cnt_r <= low_cnt_nxt;
			fired_r   <= fired_r | reached;
		end
	end
endmodule // phs_low_filter
`default_nettype wire

// *** verilog/phs_top.sv ***
// Pattern input/output request-acknowledge handshake port
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Start capturing only after in_request_n low pulse of at least 50 ns.
// - Input data present before the first recognised request never reaches host memory.
// - Every handshaked input word produces one bus-master write of that word.
// - After the host write completes, pulse in_acknowledge_n low for 100 ns.
// - One input handshake cycle lasts at least 100 ns before the next.
// - In output mode, pulse out_request_n low for 100 ns to offer a word.
// - After a request, an out_acknowledge_n low pulse of 100 ns completes transfer.
// - On the recognised acknowledge edge, start preparing the next output word.
// - All four handshake lines are active low.
module phs_top (
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire logic                        in_mode_en,
	input  wire logic                        out_mode_en,
	input  wire logic                        in_request_n,
	input  wire logic [phs_pkg::DATA_W-1:0]  in_data,
	output logic                             in_acknowledge_n,
	output logic                             bm_wr_req,
	output logic      [phs_pkg::DATA_W-1:0]  bm_wr_data,
	input  wire logic                        bm_wr_done,
	input  wire logic                        src_valid,
	input  wire logic [phs_pkg::DATA_W-1:0]  src_data,
	output logic                             src_ready,
	output logic                             out_request_n,
	input  wire logic                        out_acknowledge_n,
	output logic      [phs_pkg::DATA_W-1:0]  out_data,
	output logic                             in_overrun
);
	import phs_pkg::*;

	// Input side: request filter, capture register, FIFO, host write
	logic              req_seen;
	logic              cap_pend_r;
	logic [DATA_W-1:0] cap_data_r;
	logic              cap_push;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [DATA_W-1:0] fifo_out_data;
	logic              cap_take;
	logic              cap_pend_nxt;

	phs_in_state_e     in_state_r;
	phs_in_state_e     in_state_nxt;
	logic [CNT_W-1:0]  ack_cnt_r;
	logic [CNT_W-1:0]  ack_cnt_nxt;
	logic [CNT_W-1:0]  hs_cnt_r;
	logic [CNT_W-1:0]  hs_cnt_nxt;
	logic              in_ack_n_r;
	logic              bm_req_r;
	logic [DATA_W-1:0] bm_data_r;
	logic              overrun_r;
	logic              start_write;
	logic              ack_done;
	logic              hs_sat;
	logic              hs_met;
	logic              wr_finish;
	logic              in_ack_n_nxt;

	phs_low_filter #(
		.CNT_W      (CNT_W)
	) u_in_req_filter (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.enable     (in_mode_en),
		.min_cyc    (IN_REQ_MIN_CYC),
		.line_n     (in_request_n),
		.recognised (req_seen)
	);

	// Data is latched only on a recognised request, so earlier data is dropped
	assign cap_push     = cap_pend_r && fifo_in_ready;
	assign cap_take     = req_seen && (!cap_pend_r || cap_push);
	assign cap_pend_nxt = req_seen | (cap_pend_r & ~cap_push);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cap_pend_r <= 1'b0;
			overrun_r  <= 1'b0;
		end else begin
			cap_pend_r <= cap_pend_nxt;
			// Only reachable if the source ignores the acknowledge
			overrun_r  <= overrun_r | (req_seen & ~cap_take);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			cap_data_r <= DATA_RESET;
		else if (cap_take)
			cap_data_r <= in_data;
	end

	phs_fifo #(
		.WIDTH     (DATA_W),
		.DEPTH     (FIFO_DEPTH)
	) u_in_fifo (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.in_valid  (cap_pend_r),
		.in_ready  (fifo_in_ready),
		.in_data   (cap_data_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign fifo_out_ready = (in_state_r == PHS_IN_IDLE);
	assign start_write    = fifo_out_valid && fifo_out_ready;
	assign wr_finish      = (in_state_r == PHS_IN_WRITE) && bm_wr_done;
	assign ack_done       = (ack_cnt_r + 1'b1 >= IN_ACK_CYC);
	assign hs_sat         = (hs_cnt_r == {CNT_W{1'b1}});
	// Saturated count already meets any guard; adding one would wrap to zero
	assign hs_met         = hs_sat || (hs_cnt_r + 1'b1 >= MIN_HS_CYC);
	// Handshake cycle time counted from the request recognition
	assign hs_cnt_nxt     = req_seen ? CNT_W'(1) : (hs_sat ? hs_cnt_r : hs_cnt_r + 1'b1);
	assign in_ack_n_nxt   = (in_state_nxt != PHS_IN_ACK);

	// One word per pass: idle, host write, acknowledge
	always_comb begin
		in_state_nxt = in_state_r;
		ack_cnt_nxt  = ack_cnt_r;
		case (in_state_r)
			PHS_IN_IDLE: begin
				if (start_write)
					in_state_nxt = PHS_IN_WRITE;
			end
			PHS_IN_WRITE: begin
				// No time limit: a host that never completes holds the port here
				if (bm_wr_done) begin
					in_state_nxt = PHS_IN_ACK;
					ack_cnt_nxt  = CNT_ZERO;
				end
			end
			PHS_IN_ACK: begin
				ack_cnt_nxt = ack_cnt_r + 1'b1;
				if (ack_done && hs_met)
					in_state_nxt = PHS_IN_IDLE;
			end
			default: begin
				in_state_nxt = PHS_IN_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			in_state_r <= PHS_IN_IDLE;
			ack_cnt_r  <= CNT_ZERO;
			hs_cnt_r   <= CNT_ZERO;
		end else begin
			in_state_r <= in_state_nxt;
			ack_cnt_r  <= ack_cnt_nxt;
			hs_cnt_r   <= hs_cnt_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			bm_req_r <= 1'b0;
		else if (start_write)
			bm_req_r <= 1'b1;
		else if (wr_finish)
			bm_req_r <= 1'b0;
	end

	// Word held for the whole write, however long the host stalls
	always_ff @(posedge ref_clk) begin
		if (reset)
			bm_data_r <= DATA_RESET;
		else if (start_write)
			bm_data_r <= fifo_out_data;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			in_ack_n_r <= 1'b1;
		else
			in_ack_n_r <= in_ack_n_nxt;
	end

	// Output side: word fetch, settle, request and acknowledge
	phs_out_state_e    out_state_r;
	phs_out_state_e    out_state_nxt;
	logic [CNT_W-1:0]  out_cnt_r;
	logic [CNT_W-1:0]  out_cnt_nxt;
	logic [DATA_W-1:0] out_data_r;
	logic              out_req_n_r;
	logic              src_ready_r;
	logic              ack_seen;
	logic              ack_filter_en;
	logic              src_take;
	logic              out_req_n_nxt;
	logic              src_ready_nxt;

	// Filter armed only while a word is on offer, so a stray low is ignored;
	// mode enable left out so an offered word always completes
	assign ack_filter_en = (out_state_r == PHS_OUT_REQ) || (out_state_r == PHS_OUT_WAIT);

	// Sink lows shorter than one clock period can fall between samples
	phs_low_filter #(
		.CNT_W      (CNT_W)
	) u_out_ack_filter (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.enable     (ack_filter_en),
		.min_cyc    (OUT_ACK_CYC),
		.line_n     (out_acknowledge_n),
		.recognised (ack_seen)
	);

	assign src_take = src_ready_r && src_valid;

	// Per word: fetch, settle, request, wait for acknowledge
	always_comb begin
		out_state_nxt = out_state_r;
		out_cnt_nxt   = out_cnt_r;
		case (out_state_r)
			PHS_OUT_IDLE: begin
				if (out_mode_en)
					out_state_nxt = PHS_OUT_FETCH;
			end
			PHS_OUT_FETCH: begin
				// A word already taken is always offered, even if the mode just dropped
				if (src_take) begin
					out_state_nxt = PHS_OUT_SETTLE;
					out_cnt_nxt   = CNT_ZERO;
				end else if (!out_mode_en) begin
					out_state_nxt = PHS_OUT_IDLE;
				end
			end
			PHS_OUT_SETTLE: begin
				// New word sits on out_data before the request falls
				out_cnt_nxt = out_cnt_r + 1'b1;
				if (out_cnt_r + 1'b1 >= OUT_SETTLE_CYC) begin
					out_state_nxt = PHS_OUT_REQ;
					out_cnt_nxt   = CNT_ZERO;
				end
			end
			PHS_OUT_REQ: begin
				out_cnt_nxt = out_cnt_r + 1'b1;
				if (ack_seen)
					out_state_nxt = PHS_OUT_FETCH;
				else if (out_cnt_r + 1'b1 >= OUT_REQ_CYC)
					out_state_nxt = PHS_OUT_WAIT;
			end
			PHS_OUT_WAIT: begin
				if (ack_seen)
					out_state_nxt = PHS_OUT_FETCH;
			end
			default: begin
				out_state_nxt = PHS_OUT_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_state_r <= PHS_OUT_IDLE;
			out_cnt_r   <= CNT_ZERO;
		end else begin
			out_state_r <= out_state_nxt;
			out_cnt_r   <= out_cnt_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			out_data_r <= DATA_RESET;
		else if (src_take)
			out_data_r <= src_data;
	end

	assign out_req_n_nxt = (out_state_nxt != PHS_OUT_REQ);
	// Ready drops the cycle after a take so one word is taken per request
	assign src_ready_nxt = (out_state_nxt == PHS_OUT_FETCH) && !src_take;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_req_n_r <= 1'b1;
			src_ready_r <= 1'b0;
		end else begin
			out_req_n_r <= out_req_n_nxt;
			src_ready_r <= src_ready_nxt;
		end
	end

	assign in_acknowledge_n = in_ack_n_r;
	assign bm_wr_req        = bm_req_r;
	assign bm_wr_data       = bm_data_r;
	assign out_request_n    = out_req_n_r;
	assign out_data         = out_data_r;
	assign src_ready        = src_ready_r;
	assign in_overrun       = overrun_r;
endmodule // phs_top
`default_nettype wire
